// ---- include/swdt_pkg.sv ----
// constants and types shared by the system watchdog timer files
package swdt_pkg;
   // register bus shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_SETTING = 8'h04;
   localparam logic [7:0] OFF_COUNT = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_CLEAR = 8'h10;
   localparam logic [7:0] OFF_ENABLE = 8'h14;
   // command bits of the control register
   localparam int CTRL_BEGIN = 0;
   localparam int CTRL_RELOAD = 1;
   localparam int CTRL_HALT = 2;
   localparam int CTRL_RUNNING = 0;
   // timeout setting layout
   localparam int TICK_W = 8;
   localparam int SET_TICK_LSB = 0;
   localparam int SET_UNIT_BIT = 8;
   localparam logic [7:0] TICK_ZERO = 8'h00;
   localparam logic [7:0] TICK_LAST = 8'h01;
   localparam logic UNIT_SECOND = 1'b0;
   localparam logic UNIT_MINUTE = 1'b1;
   // event bits of status, clear and enable
   localparam int EVT_W = 2;
   localparam int EVT_EXPIRED = 0;
   localparam int EVT_INVALID = 1;
   // time base
   localparam longint CLK_PERIOD_NS = 40;
   localparam longint SECOND_NS = 1000000000;
   localparam int CYCLES_PER_SECOND = int'(SECOND_NS / CLK_PERIOD_NS);
   localparam int SECONDS_PER_MINUTE = 60;
   // length of the outgoing system reset, in clock cycles
   localparam int RESET_PULSE_W = 5;
   localparam logic [4:0] RESET_PULSE_CYCLES = 5'h10;
   localparam logic [4:0] RESET_CNT_ZERO = 5'h00;
   localparam logic [4:0] RESET_CNT_ONE = 5'h01;
   // watchdog run state
   typedef enum logic {
      ST_STOPPED = 1'b0,
      ST_RUNNING = 1'b1
   } swdt_state_e;
endpackage

// ---- logic/swdt_prescaler.sv ----
// divides a stream of step pulses by a fixed ratio
`timescale 1ns/1ps
module swdt_prescaler #(
   parameter int unsigned DIV = 60
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic clear_i,
   input wire logic step_i,
   output logic pulse_o
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   localparam logic [CW-1:0] ONE = CW'(1);

   logic [CW-1:0] count;
   logic at_last;

   // one pulse per DIV steps; clear restarts the phase
   assign at_last = (count == LAST);
   assign pulse_o = step_i && at_last && !clear_i;

   // phase counter
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || clear_i) begin
         count <= '0;
      end else if (step_i) begin
         count <= at_last ? '0 : count + ONE;
      end
   end
endmodule // swdt_prescaler

// ---- logic/swdt_irq.sv ----
// sticky event status, enable mask and level interrupt
`timescale 1ns/1ps
module swdt_irq (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic [swdt_pkg::EVT_W-1:0] evt_i,
   input wire logic clr_we_i,
   input wire logic en_we_i,
   input wire logic [swdt_pkg::EVT_W-1:0] wdata_i,
   output logic [swdt_pkg::EVT_W-1:0] status_o,
   output logic [swdt_pkg::EVT_W-1:0] enable_o,
   output logic irq_o
);
   logic [swdt_pkg::EVT_W-1:0] clr_mask;
   logic [swdt_pkg::EVT_W-1:0] next_status;

   // a new event wins over a clear in the same cycle
   assign clr_mask = clr_we_i ? wdata_i : '0;
   assign next_status = (status_o & ~clr_mask) | evt_i;
   assign irq_o = |(status_o & enable_o);

   // status and mask registers
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         status_o <= '0;
         enable_o <= '0;
      end else begin
         status_o <= next_status;
         if (en_we_i) begin
            enable_o <= wdata_i;
         end
      end
   end
endmodule // swdt_irq

// ---- logic/swdt_core.sv ----
// system watchdog: timeout setting, countdown, system reset and registers
//
// Notes on behaviour
// - expiry while running raises the system reset output.
// - tick count is 1 to 255; a zero setting is refused as invalid.
// - unit 0 makes each tick one second.
// - unit 1 makes each tick one minute.
// - begin loads the timeout and starts; nothing expires before that.
// - reload while running restores the latest programmed timeout.
// - halt stops the countdown; no new system reset starts while stopped.
`timescale 1ns/1ps
module swdt_core #(
   parameter int unsigned CYCLES_PER_SECOND = swdt_pkg::CYCLES_PER_SECOND
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic [swdt_pkg::ADDR_W-1:0] addr_i,
   input wire logic [swdt_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [swdt_pkg::DATA_W-1:0] rdata_o,
   output logic sys_reset_o,
   output logic irq_o
);
   swdt_pkg::swdt_state_e state;
   swdt_pkg::swdt_state_e next_state;
   logic [swdt_pkg::TICK_W-1:0] set_tick;
   logic set_unit;
   logic [swdt_pkg::TICK_W-1:0] count;
   logic [swdt_pkg::TICK_W-1:0] next_count;
   logic [swdt_pkg::RESET_PULSE_W-1:0] rst_cnt;
   logic [swdt_pkg::EVT_W-1:0] evt;
   logic [swdt_pkg::EVT_W-1:0] status;
   logic [swdt_pkg::EVT_W-1:0] enable;
   logic [swdt_pkg::DATA_W-1:0] rd_mux;

   // address decode
   wire wr_ctrl = wr_i && (addr_i == swdt_pkg::OFF_CTRL);
   wire wr_setting = wr_i && (addr_i == swdt_pkg::OFF_SETTING);
   wire wr_clear = wr_i && (addr_i == swdt_pkg::OFF_CLEAR);
   wire wr_enable = wr_i && (addr_i == swdt_pkg::OFF_ENABLE);

   // commands carried by a control write; halt has priority
   wire cmd_halt = wr_ctrl && wdata_i[swdt_pkg::CTRL_HALT];
   wire cmd_reload = wr_ctrl && wdata_i[swdt_pkg::CTRL_RELOAD] && !cmd_halt;
   wire cmd_begin = wr_ctrl && wdata_i[swdt_pkg::CTRL_BEGIN] && !cmd_halt;
   wire running = (state == swdt_pkg::ST_RUNNING);

   // setting fields of a write
   wire [swdt_pkg::TICK_W-1:0] wr_tick = wdata_i[swdt_pkg::SET_TICK_LSB +: swdt_pkg::TICK_W];
   wire wr_unit = wdata_i[swdt_pkg::SET_UNIT_BIT];
   wire setting_ok = (wr_tick != swdt_pkg::TICK_ZERO);
   wire have_timeout = (set_tick != swdt_pkg::TICK_ZERO);

   // accepted commands
   wire start_ok = cmd_begin && !running && have_timeout;
   wire reload_ok = cmd_reload && running;
   wire restart = start_ok || reload_ok;

   // tick generation: seconds from the clock, minutes from seconds
   wire base_clear = restart || !running;
   wire sec_pulse;
   wire min_pulse;
   wire one_step = 1'b1;

   swdt_prescaler #(
      .DIV(CYCLES_PER_SECOND)
   ) u_sec (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .clear_i(base_clear),
      .step_i(one_step),
      .pulse_o(sec_pulse)
   );

   swdt_prescaler #(
      .DIV(swdt_pkg::SECONDS_PER_MINUTE)
   ) u_min (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .clear_i(base_clear),
      .step_i(sec_pulse),
      .pulse_o(min_pulse)
   );

   // unit selects which pulse decrements the countdown
   wire unit_tick = (set_unit == swdt_pkg::UNIT_MINUTE) ? min_pulse : sec_pulse;

   // expiry: last tick runs out with no halt or accepted reload in the same cycle
   wire expire = running && unit_tick && (count == swdt_pkg::TICK_LAST)
                 && !cmd_halt && !reload_ok;

   // events towards the interrupt block
   wire invalid_evt = (wr_setting && !setting_ok) || (cmd_begin && !running && !have_timeout);
   assign evt[swdt_pkg::EVT_EXPIRED] = expire;
   assign evt[swdt_pkg::EVT_INVALID] = invalid_evt;

   // next state and countdown
   always_comb begin
      next_state = state;
      next_count = count;
      if (cmd_halt) begin
         next_state = swdt_pkg::ST_STOPPED;
      end else if (restart) begin
         next_state = swdt_pkg::ST_RUNNING;
         next_count = set_tick;
      end else if (expire) begin
         next_state = swdt_pkg::ST_STOPPED;
         next_count = swdt_pkg::TICK_ZERO;
      end else if (running && unit_tick) begin
         next_count = count - swdt_pkg::TICK_LAST;
      end
   end

   // state, countdown and setting registers
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         state <= swdt_pkg::ST_STOPPED;
         count <= swdt_pkg::TICK_ZERO;
         set_tick <= swdt_pkg::TICK_ZERO;
         set_unit <= swdt_pkg::UNIT_SECOND;
      end else begin
         state <= next_state;
         count <= next_count;
         if (wr_setting && setting_ok) begin
            set_tick <= wr_tick;
            set_unit <= wr_unit;
         end
      end
   end

   // outgoing system reset, held for a fixed number of cycles
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         sys_reset_o <= 1'b0;
         rst_cnt <= swdt_pkg::RESET_CNT_ZERO;
      end else if (expire) begin
         sys_reset_o <= 1'b1;
         rst_cnt <= swdt_pkg::RESET_PULSE_CYCLES - swdt_pkg::RESET_CNT_ONE;
      end else if (rst_cnt != swdt_pkg::RESET_CNT_ZERO) begin
         rst_cnt <= rst_cnt - swdt_pkg::RESET_CNT_ONE;
      end else begin
         sys_reset_o <= 1'b0;
      end
   end

   // sticky events, mask and interrupt line
   swdt_irq u_irq (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .evt_i(evt),
      .clr_we_i(wr_clear),
      .en_we_i(wr_enable),
      .wdata_i(wdata_i[swdt_pkg::EVT_W-1:0]),
      .status_o(status),
      .enable_o(enable),
      .irq_o(irq_o)
   );

   // read selection; unmapped addresses and the clear register read zero
   always_comb begin
      rd_mux = '0;
      case (addr_i)
         swdt_pkg::OFF_CTRL: begin
            rd_mux[swdt_pkg::CTRL_RUNNING] = running;
         end
         swdt_pkg::OFF_SETTING: begin
            rd_mux[swdt_pkg::SET_TICK_LSB +: swdt_pkg::TICK_W] = set_tick;
            rd_mux[swdt_pkg::SET_UNIT_BIT] = set_unit;
         end
         swdt_pkg::OFF_COUNT: begin
            rd_mux[swdt_pkg::TICK_W-1:0] = count;
         end
         swdt_pkg::OFF_STATUS: begin
            rd_mux[swdt_pkg::EVT_W-1:0] = status;
         end
         swdt_pkg::OFF_ENABLE: begin
            rd_mux[swdt_pkg::EVT_W-1:0] = enable;
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= rd_i ? rd_mux : '0;
      end
   end

   // ---- checks ----
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   // helper: a start has been accepted since reset
   logic started;
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         started <= 1'b0;
      end else if (start_ok) begin
         started <= 1'b1;
      end
   end

   // helper: cycles since the last second pulse while running
   logic [31:0] sec_gap;
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || base_clear || sec_pulse) begin
         sec_gap <= '0;
      end else begin
         sec_gap <= sec_gap + 32'h00000001;
      end
   end

   property p_expire_reset;
      running && unit_tick && (count == swdt_pkg::TICK_LAST) && !wr_ctrl
      |=> sys_reset_o && !running ##1 sys_reset_o [*8];
   endproperty
   a_expire_reset: assert property (p_expire_reset) else $error("expiry did not reset");

   property p_zero_refused;
      wr_setting && (wr_tick == swdt_pkg::TICK_ZERO)
      |=> $stable(set_tick) && status[swdt_pkg::EVT_INVALID];
   endproperty
   a_zero_refused: assert property (p_zero_refused) else $error("zero tick accepted");

   property p_second_unit;
      running && (set_unit == swdt_pkg::UNIT_SECOND) |-> (unit_tick == sec_pulse);
   endproperty
   a_second_unit: assert property (p_second_unit) else $error("second tick wrong");

   property p_minute_unit;
      running && (set_unit == swdt_pkg::UNIT_MINUTE) && unit_tick |-> sec_pulse;
   endproperty
   a_minute_unit: assert property (p_minute_unit) else $error("minute tick off second");

   property p_begin_load;
      cmd_begin && !running && have_timeout
      |=> running && (count == $past(set_tick)) && (count != swdt_pkg::TICK_ZERO);
   endproperty
   a_begin_load: assert property (p_begin_load) else $error("begin did not load");

   property p_no_early_reset;
      !started |-> !sys_reset_o && !running;
   endproperty
   a_no_early_reset: assert property (p_no_early_reset) else $error("reset before begin");

   property p_reload;
      running && cmd_reload |=> running && (count == $past(set_tick));
   endproperty
   a_reload: assert property (p_reload) else $error("reload lost");

   property p_halt_quiet;
      cmd_halt && !sys_reset_o |=> !running && !sys_reset_o ##1 !sys_reset_o;
   endproperty
   a_halt_quiet: assert property (p_halt_quiet) else $error("reset while stopped");

   property p_after_reset;
      $rose(resetn_i) |-> !running && (set_tick == swdt_pkg::TICK_ZERO) && !sys_reset_o;
   endproperty
   a_after_reset: assert property (p_after_reset) else $error("not stopped after reset");

   property p_sec_period;
      sec_pulse |-> (sec_gap == 32'(CYCLES_PER_SECOND - 1));
   endproperty
   a_sec_period: assert property (p_sec_period) else $error("second period wrong");

   c_expire: cover property (expire ##1 sys_reset_o);
   c_reload: cover property (reload_ok ##1 running);
   c_halt: cover property (running ##1 cmd_halt ##1 !running);
   c_minute: cover property (running && (set_unit == swdt_pkg::UNIT_MINUTE) && unit_tick);
endmodule // swdt_core

// ---- verification/tb_system_watchdog_timer.sv ----
// self-checking testbench for the system watchdog core
`timescale 1ns/1ps
module tb_system_watchdog_timer;
   localparam int CPS = 4;
   logic clk_sys_i;
   logic resetn_i;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr_s;
   logic rd_s;
   logic [31:0] rdata_o;
   logic sys_reset_o;
   logic irq_o;
   int fails;
   int check_count;

   swdt_core #(.CYCLES_PER_SECOND(CPS)) dut (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .addr_i(addr),
      .wdata_i(wdata),
      .wr_i(wr_s),
      .rd_i(rd_s),
      .rdata_o(rdata_o),
      .sys_reset_o(sys_reset_o),
      .irq_o(irq_o)
   );

   // 25 MHz system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   // verdict and end of run
   task automatic finish_test();
      if (fails == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // compare one value against its expectation
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk_sys_i);
      wr_s <= 1'b0;
   endtask

   // one-cycle register read, data judged in the following cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys_i);
      rd_s <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   // tick count in bits 7:0, unit in bit 8
   function automatic logic [31:0] setting(input logic [7:0] t, input logic u);
      return {23'h000000, u, t};
   endfunction

   // count edges from the last taken write until the system reset, then its width
   task automatic expect_reset(input int exp_n);
      int n;
      int w;
      n = 0;
      w = 1;
      do begin
         @(posedge clk_sys_i);
         #1;
         n++;
         if (n > 70000) begin
            fails++;
            finish_test();
         end
      end while (sys_reset_o !== 1'b1);
      check(n, exp_n);
      do begin
         @(posedge clk_sys_i);
         #1;
         if (sys_reset_o === 1'b1) w++;
      end while (sys_reset_o === 1'b1 && w < 100);
      check(w, 16);
   endtask

   // registers after reset, unmapped address included
   task automatic t_reset_values();
      logic [31:0] d;
      rd(swdt_pkg::OFF_CTRL, d);
      check(d, 32'h00000000);
      rd(swdt_pkg::OFF_SETTING, d);
      check(d, 32'h00000000);
      rd(swdt_pkg::OFF_COUNT, d);
      check(d, 32'h00000000);
      rd(swdt_pkg::OFF_STATUS, d);
      check(d, 32'h00000000);
      rd(8'h18, d);
      check(d, 32'h00000000);
      check(sys_reset_o, 1'b0);
   endtask

   // begin without setting and zero tick are refused, raising the invalid event
   task automatic t_invalid();
      logic [31:0] d;
      wr(swdt_pkg::OFF_CTRL, 32'h00000001);
      rd(swdt_pkg::OFF_STATUS, d);
      check(d, 32'h00000002);
      rd(swdt_pkg::OFF_CTRL, d);
      check(d, 32'h00000000);
      wr(swdt_pkg::OFF_ENABLE, 32'h00000002);
      #1;
      check(irq_o, 1'b1);
      rd(swdt_pkg::OFF_ENABLE, d);
      check(d, 32'h00000002);
      wr(swdt_pkg::OFF_CLEAR, 32'h00000002);
      #1;
      check(irq_o, 1'b0);
      wr(swdt_pkg::OFF_SETTING, setting(8'h00, 1'b0));
      rd(swdt_pkg::OFF_STATUS, d);
      check(d, 32'h00000002);
      rd(swdt_pkg::OFF_SETTING, d);
      check(d, 32'h00000000);
      wr(swdt_pkg::OFF_CLEAR, 32'h00000003);
   endtask

   // full timeout with no reload, for one tick count and unit
   task automatic t_expiry(input logic [7:0] t, input logic u);
      logic [31:0] d;
      wr(swdt_pkg::OFF_SETTING, setting(t, u));
      wr(swdt_pkg::OFF_ENABLE, 32'h00000001);
      wr(swdt_pkg::OFF_CTRL, 32'h00000001);
      expect_reset(int'(t) * CPS * (u ? 60 : 1));
      rd(swdt_pkg::OFF_STATUS, d);
      check(d, 32'h00000001);
      // read data stands for one cycle only, then returns to zero
      @(posedge clk_sys_i);
      #1;
      check(rdata_o, 32'h00000000);
      check(irq_o, 1'b1);
      rd(swdt_pkg::OFF_CTRL, d);
      check(d, 32'h00000000);
      wr(swdt_pkg::OFF_CLEAR, 32'h00000001);
   endtask

   // reload restores the most recently programmed timeout
   task automatic t_reload();
      logic [31:0] d;
      wr(swdt_pkg::OFF_SETTING, setting(8'h02, 1'b0));
      wr(swdt_pkg::OFF_CTRL, 32'h00000001);
      rd(swdt_pkg::OFF_COUNT, d);
      check(d, 32'h00000002);
      wr(swdt_pkg::OFF_SETTING, setting(8'h03, 1'b0));
      wr(swdt_pkg::OFF_CTRL, 32'h00000002);
      expect_reset(3 * CPS);
      wr(swdt_pkg::OFF_CLEAR, 32'h00000001);
   endtask

   // halt stops the countdown and wins in a combined write; reload while stopped stays ignored
   task automatic t_halt();
      logic [31:0] d;
      int hit;
      hit = 0;
      wr(swdt_pkg::OFF_SETTING, setting(8'h02, 1'b0));
      wr(swdt_pkg::OFF_CTRL, 32'h00000001);
      repeat (3) @(posedge clk_sys_i);
      wr(swdt_pkg::OFF_CTRL, 32'h00000007);
      wr(swdt_pkg::OFF_CTRL, 32'h00000002);
      repeat (40) begin
         @(posedge clk_sys_i);
         #1;
         if (sys_reset_o !== 1'b0) hit++;
      end
      check(hit, 0);
      rd(swdt_pkg::OFF_CTRL, d);
      check(d, 32'h00000000);
      rd(swdt_pkg::OFF_STATUS, d);
      check(d, 32'h00000000);
   endtask

   // main sequence
   initial begin
      fails = 0;
      check_count = 0;
      resetn_i = 1'b0;
      addr = 8'h00;
      wdata = 32'h00000000;
      wr_s = 1'b0;
      rd_s = 1'b0;
      repeat (5) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      t_reset_values();
      t_invalid();
      t_expiry(8'h01, 1'b0);
      t_expiry(8'hFF, 1'b0);
      t_expiry(8'h02, 1'b1);
      t_reload();
      t_halt();
      finish_test();
   end
endmodule // tb_system_watchdog_timer
